// [logic/tthc_map.svh]
// Register offsets, field positions, reset values and timing counts of the throttle block
`ifndef TTHC_MAP_SVH
`define TTHC_MAP_SVH

`define TTHC_CLK_MHZ 125
`define TTHC_GATE_PERIOD_NS 32000
`define TTHC_GATE_PERIOD_CYC ((`TTHC_GATE_PERIOD_NS * `TTHC_CLK_MHZ) / 1000)
`define TTHC_GATE_ON_CYC (`TTHC_GATE_PERIOD_CYC / 4)
`define TTHC_PECI_WIN_MS 256
`define TTHC_PECI_WIN_CYC (`TTHC_PECI_WIN_MS * `TTHC_CLK_MHZ * 1000)

`define TTHC_OFS_CEIL 12'h000
`define TTHC_OFS_CTRL 12'h004
`define TTHC_OFS_TEMP 12'h008
`define TTHC_OFS_STAT 12'h00C
`define TTHC_OFS_PREQ 12'h010
`define TTHC_OFS_THR 12'h014

`define TTHC_CEIL_LSB 16
`define TTHC_CTRL_OFFS_LSB 0
`define TTHC_CTRL_WIN_LSB 8
`define TTHC_CTRL_BIDIR_BIT 16
`define TTHC_CTRL_HIE_BIT 17
`define TTHC_CTRL_TIE_BIT 18
`define TTHC_CTRL_RESET 32'h0000_0000
`define TTHC_THR_RESET 32'h0000_0000

`endif

// [logic/tthc_pkg.sv]
// Types shared by the throttle block
package tthc_pkg;
  typedef enum logic [1:0] {
    TTHC_IDLE = 2'b00,
    TTHC_VOLT = 2'b01,
    TTHC_FREQ = 2'b11,
    TTHC_VOLT_DN = 2'b10
  } tthc_step_type;
  typedef struct packed {
    logic [7:0] ratio;
    logic [7:0] volt;
  } tthc_point_type;
endpackage

// [logic/tthc_top.sv]
// Thermal throttle control with AXI4-Lite register access
`timescale 1ns/1ps
`include "tthc_map.svh"
module tthc_top #(
  parameter int NSENS = 4,
  parameter logic [7:0] CEIL_CAL = 8'h64,
  parameter logic [7:0] MIN_RATIO = 8'h08,
  parameter logic [7:0] MAX_RATIO = 8'h30,
  parameter int HYST_CYC = 1000,
  parameter int GATE_CYC = `TTHC_GATE_PERIOD_CYC,
  parameter int PECI_CYC = `TTHC_PECI_WIN_CYC,
  parameter int STEP_CYC = 64
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NSENS*8-1:0] on_die_temp_sensor,
  input wire logic package_hot_line_n_in,
  output logic package_hot_line_n_out,
  output logic package_hot_line_n_oe,
  output tthc_pkg::tthc_point_type op_point,
  output logic exec_stall,
  output logic core_clk_gate,
  output logic thermal_irq_req,
  output logic [7:0] peci_temp
);
  import tthc_pkg::*;

  // Register storage
  logic [31:0] ctrl;
  logic [31:0] thr;
  logic [7:0] preq;
  logic [2:0] stat;
  // AXI handshake state
  logic aw_held, w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Field views
  logic [7:0] act_offs, win;
  logic bidir;
  assign act_offs = ctrl[`TTHC_CTRL_OFFS_LSB +: 8];
  assign win = ctrl[`TTHC_CTRL_WIN_LSB +: 8];
  assign bidir = ctrl[`TTHC_CTRL_BIDIR_BIT];

  // Hottest sensor: smallest distance below ceiling
  logic [7:0] hot_dist;
  always_comb begin
    hot_dist = 8'hFF;
    for (int i = 0; i < NSENS; i++) begin
      if (on_die_temp_sensor[i*8 +: 8] < hot_dist) begin
        hot_dist = on_die_temp_sensor[i*8 +: 8];
      end
    end
  end

  // Instantaneous trigger at ceiling or offset set point
  logic at_ceiling, at_setpt;
  assign at_ceiling = (hot_dist == 8'h00);
  assign at_setpt = (win == 8'h00) && (hot_dist <= act_offs);

  // Weighted average of distance, shift set by window
  logic [15:0] avg;
  logic avg_hot;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      avg <= 16'hFF00;
    end else begin
      avg <= 16'(avg - (avg >> win[3:0]) + ({hot_dist, 8'h00} >> win[3:0]));
    end
  end
  assign avg_hot = (win != 8'h00) && (avg[15:8] <= act_offs);

  // Instant trigger, with hysteresis hold before release
  logic inst_trig, tcc_on;
  logic [$clog2(HYST_CYC+1)-1:0] hyst;
  assign inst_trig = at_ceiling || at_setpt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tcc_on <= 1'b0;
      hyst <= '0;
    end else if (inst_trig) begin
      tcc_on <= 1'b1;
      hyst <= ($clog2(HYST_CYC+1))'(HYST_CYC);
    end else if (hyst != '0) begin
      hyst <= hyst - 1'b1;
    end else begin
      tcc_on <= 1'b0;
    end
  end

  // Hot line input through three flops
  logic [2:0] hot_sync;
  logic [2:0] oe_hist; // Own drive still travelling through the sync flops
  logic ext_hot, ext_hot_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hot_sync <= 3'b111;
      oe_hist <= 3'b000;
      ext_hot <= 1'b0;
      ext_hot_q <= 1'b0;
    end else begin
      hot_sync <= {hot_sync[1:0], package_hot_line_n_in};
      oe_hist <= {oe_hist[1:0], package_hot_line_n_oe};
      if (hot_sync[2] == hot_sync[1]) begin
        // Own drive masks the line until its low level has left the flops
        ext_hot <= !hot_sync[2] && !package_hot_line_n_oe && oe_hist == 3'b000;
      end
      ext_hot_q <= ext_hot;
    end
  end

  // Hot line drive only when bidirectional
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      package_hot_line_n_oe <= 1'b0;
    end else begin
      package_hot_line_n_oe <= bidir && tcc_on;
    end
  end
  assign package_hot_line_n_out = 1'b0;

  // Target ratio choice
  logic [7:0] therm_ratio, target_ratio;
  logic [7:0] cur_ratio;
  logic throttle;
  assign throttle = tcc_on || avg_hot;
  always_comb begin
    therm_ratio = MAX_RATIO;
    if (ext_hot) begin
      therm_ratio = MIN_RATIO;
    end else if (throttle) begin
      therm_ratio = (cur_ratio > MIN_RATIO) ? 8'(cur_ratio - 1'b1) : MIN_RATIO;
    end
    // Lower request honoured, higher deferred
    target_ratio = (preq != 8'h00 && preq < therm_ratio) ? preq : therm_ratio;
    if (target_ratio < MIN_RATIO) begin
      target_ratio = MIN_RATIO;
    end
  end

  // Operating point sequencer
  tthc_step_type step;
  logic [$clog2(STEP_CYC+1)-1:0] step_cnt;
  logic [7:0] goal;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step <= TTHC_IDLE;
      step_cnt <= '0;
      goal <= MAX_RATIO;
      cur_ratio <= MAX_RATIO;
      op_point <= '{ratio: MAX_RATIO, volt: MAX_RATIO};
    end else if (step_cnt != '0) begin
      step_cnt <= step_cnt - 1'b1;
    end else begin
      unique case (step)
        TTHC_IDLE: begin
          if (target_ratio > cur_ratio) begin
            goal <= target_ratio;
            op_point.volt <= target_ratio;
            step <= TTHC_VOLT;
            step_cnt <= ($clog2(STEP_CYC+1))'(STEP_CYC);
          end else if (target_ratio < cur_ratio) begin
            goal <= target_ratio;
            op_point.ratio <= target_ratio;
            step <= TTHC_VOLT_DN;
            step_cnt <= ($clog2(STEP_CYC+1))'(STEP_CYC);
          end
        end
        TTHC_VOLT: begin
          op_point.ratio <= goal;
          step <= TTHC_FREQ;
          step_cnt <= ($clog2(STEP_CYC+1))'(STEP_CYC);
        end
        TTHC_FREQ: begin
          cur_ratio <= goal;
          step <= TTHC_IDLE;
        end
        TTHC_VOLT_DN: begin
          op_point.volt <= goal;
          cur_ratio <= goal;
          step <= TTHC_IDLE;
        end
      endcase
    end
  end
  // Stall while frequency moves
  assign exec_stall = (step == TTHC_FREQ) || (step == TTHC_VOLT_DN && step_cnt != '0);

  // Clock gating timer, instant path at minimum only
  logic [$clog2(GATE_CYC)-1:0] gate_cnt;
  logic gate_act;
  assign gate_act = tcc_on && !ext_hot && cur_ratio == MIN_RATIO;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_cnt <= '0;
      core_clk_gate <= 1'b0;
    end else if (!gate_act) begin
      gate_cnt <= '0;
      core_clk_gate <= 1'b0;
    end else begin
      gate_cnt <= (gate_cnt == ($clog2(GATE_CYC))'(GATE_CYC - 1)) ? '0 : gate_cnt + 1'b1;
      core_clk_gate <= gate_cnt >= ($clog2(GATE_CYC))'(GATE_CYC / 4);
    end
  end

  // Window-averaged maximum for the PECI side
  logic [$clog2(PECI_CYC)-1:0] peci_cnt;
  logic [7:0] peci_min;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      peci_cnt <= '0;
      peci_min <= 8'hFF;
      peci_temp <= 8'hFF;
    end else if (peci_cnt == ($clog2(PECI_CYC))'(PECI_CYC - 1)) begin
      peci_cnt <= '0;
      peci_temp <= 8'((16'(peci_temp) + 16'(peci_min)) >> 1);
      peci_min <= 8'hFF;
    end else begin
      peci_cnt <= peci_cnt + 1'b1;
      if (hot_dist < peci_min) begin
        peci_min <= hot_dist;
      end
    end
  end

  // Sticky status: ceiling hit, hot edge, threshold cross
  logic thr_hit;
  logic thr_hit_q;
  assign thr_hit = (hot_dist <= thr[7:0]) || (hot_dist <= thr[15:8]);
  logic st_clr;
  logic [2:0] st_mask;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat <= 3'b000;
      thr_hit_q <= 1'b0;
    end else begin
      thr_hit_q <= thr_hit;
      // Set wins over write-one-clear
      stat <= (stat & ~(st_clr ? st_mask : 3'b000))
        | {thr_hit ^ thr_hit_q, ext_hot ^ ext_hot_q, at_ceiling};
    end
  end
  assign thermal_irq_req = (stat[2] && ctrl[`TTHC_CTRL_TIE_BIT])
    || (stat[1] && ctrl[`TTHC_CTRL_HIE_BIT]);

  // AXI write channel capture
  logic wr_go;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign st_clr = wr_go && aw_addr == `TTHC_OFS_STAT;
  assign st_mask = w_data[2:0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      ctrl <= `TTHC_CTRL_RESET;
      thr <= `TTHC_THR_RESET;
      preq <= 8'h00;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        // Ceiling register is read-only
        unique case (aw_addr)
          `TTHC_OFS_CTRL: begin
            for (int b = 0; b < 4; b++) begin
              if (w_strb[b]) ctrl[b*8 +: 8] <= w_data[b*8 +: 8];
            end
          end
          `TTHC_OFS_THR: begin
            for (int b = 0; b < 2; b++) begin
              if (w_strb[b]) thr[b*8 +: 8] <= w_data[b*8 +: 8];
            end
          end
          `TTHC_OFS_PREQ: begin
            if (w_strb[0]) preq <= w_data[7:0];
          end
          `TTHC_OFS_STAT, `TTHC_OFS_CEIL, `TTHC_OFS_TEMP: begin
          end
          default: s_axi_bresp <= 2'b10;
        endcase
      end
    end
  end

  // AXI read channel
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      unique case (s_axi_araddr)
        `TTHC_OFS_CEIL: s_axi_rdata <= {8'h00, CEIL_CAL, 16'h0000};
        `TTHC_OFS_CTRL: s_axi_rdata <= ctrl;
        `TTHC_OFS_TEMP: s_axi_rdata <= {8'h00, cur_ratio, 8'h00, hot_dist};
        `TTHC_OFS_STAT: s_axi_rdata <= {26'h0, ext_hot, tcc_on, 1'b0, stat};
        `TTHC_OFS_PREQ: s_axi_rdata <= {24'h0, preq};
        `TTHC_OFS_THR: s_axi_rdata <= {16'h0, thr[15:0]};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// [dv/tthc_properties.sv]
// Concurrent checks on the throttle block ports
`timescale 1ns/1ps
module tthc_properties
  import tthc_pkg::*;
#(
  parameter logic [7:0] MIN_RATIO = 8'h08,
  parameter int GATE_CYC = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic package_hot_line_n_in,
  input wire logic package_hot_line_n_oe,
  input wire tthc_pkg::tthc_point_type op_point,
  input wire logic exec_stall,
  input wire logic core_clk_gate,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  logic [15:0] off_len; // Length of the current clocks-off span
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Count consecutive gated cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      off_len <= 16'h0000;
    end else if (core_clk_gate) begin
      off_len <= off_len + 16'h0001;
    end else begin
      off_len <= 16'h0000;
    end
  end
  // Platform holds the line while the device is quiet
  sequence ext_hot_s;
    (!package_hot_line_n_oe && !package_hot_line_n_in)[*8];
  endsequence
  // Operating point moving up or down
  sequence ratio_up_s;
    op_point.ratio > $past(op_point.ratio);
  endsequence
  sequence volt_dn_s;
    op_point.volt < $past(op_point.volt);
  endsequence
  oe_after_reset_a: assert property ($rose(aresetn) |-> !package_hot_line_n_oe)
    else $error("hot line driven right after reset");
  gate_off_len_a: assert property ($fell(core_clk_gate) |-> off_len <= GATE_CYC * 3 / 4)
    else $error("clocks off longer than three quarters of a period");
  gate_at_min_a: assert property (core_clk_gate |-> op_point.ratio == MIN_RATIO)
    else $error("clock gating above minimum ratio");
  volt_first_up_a: assert property (ratio_up_s |-> op_point.volt >= op_point.ratio)
    else $error("frequency rose before voltage");
  freq_first_dn_a: assert property (volt_dn_s |-> op_point.ratio <= op_point.volt)
    else $error("voltage fell before frequency");
  stall_on_step_a: assert property ($changed(op_point.ratio) |-> exec_stall || $past(exec_stall))
    else $error("ratio changed without stall");
  ext_hot_min_a: assert property (ext_hot_s |-> ##[0:1000] op_point.ratio == MIN_RATIO)
    else $error("external hot did not reach lowest ratio");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before taken");
endmodule

// [dv/tthc_hot_agent.sv]
// Platform component sharing the active-low hot line
`timescale 1ns/1ps
module tthc_hot_agent (
  input wire logic aclk,
  input wire logic hot_req,
  input wire logic dut_oe,
  input wire logic dut_out,
  output logic line_n
);
  logic drive_low = 1'h0; // Component pulling the line
  // Assert and release only right after an edge
  always_ff @(posedge aclk) begin
    drive_low <= hot_req;
  end
  // Pulled-up wire: any driver wins low
  assign line_n = !(drive_low || (dut_oe && !dut_out));
endmodule

// [dv/tb_top.sv]
// Self-checking bench for the thermal throttle block
`timescale 1ns/1ps
module tb_top;
  import tthc_pkg::*;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic [1:0] r;
  } tthc_exp_type;
  localparam logic [7:0] CEIL = 8'h64;
  localparam logic [7:0] MIN_R = 8'h08;
  localparam logic [7:0] MAX_R = 8'h30;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic hot_req = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic [31:0] on_die_temp_sensor = 32'hFFFF_FFFF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic package_hot_line_n_in, package_hot_line_n_out, package_hot_line_n_oe;
  logic exec_stall, core_clk_gate, thermal_irq_req;
  logic [7:0] peci_temp;
  tthc_point_type op_point;
  tthc_exp_type exp_q[$]; // Expected read answers, oldest first
  tthc_exp_type exp_c;
  int n_mismatch = 0;
  int num_checks = 0;
  always #4 aclk = ~aclk;
  tthc_top #(.CEIL_CAL(CEIL), .MIN_RATIO(MIN_R), .MAX_RATIO(MAX_R), .HYST_CYC(10),
    .GATE_CYC(16), .PECI_CYC(32), .STEP_CYC(4)) dut_u (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .on_die_temp_sensor,
    .package_hot_line_n_in, .package_hot_line_n_out, .package_hot_line_n_oe, .op_point,
    .exec_stall, .core_clk_gate, .thermal_irq_req, .peci_temp);
  tthc_hot_agent agent_u (.aclk, .hot_req, .dut_oe(package_hot_line_n_oe),
    .dut_out(package_hot_line_n_out), .line_n(package_hot_line_n_in));
  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tmo();
    n_mismatch++;
    summarize();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Register write, both channels offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'h0;
    if (n == 100) tmo();
  endtask
  // Register read, expectation noted first
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
    input logic [1:0] r);
    int n;
    @(posedge aclk);
    exp_q.push_back('{d, m, r});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'h0;
    if (n == 100) tmo();
  endtask
  // Read answers compared against the oldest note
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'h1 && s_axi_rready && exp_q.size() > 0) begin
      exp_c = exp_q.pop_front();
      chk("rdata", exp_c.d & exp_c.m, s_axi_rdata & exp_c.m);
      chk("rresp", 32'(exp_c.r), 32'(s_axi_rresp));
    end
  end
  task automatic wait_ratio(input logic [7:0] r);
    int n;
    for (n = 0; n < 3000 && op_point.ratio !== r; n++) @(posedge aclk);
    chk("ratio", 32'(r), 32'(op_point.ratio));
    if (n == 3000) tmo();
  endtask
  // Clocks-off cycles over four gating periods
  task automatic gate_cnt(input int e);
    int n;
    int c;
    c = 0;
    for (n = 0; n < 64 && e > 0 && core_clk_gate !== 1'h1; n++) @(posedge aclk);
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (core_clk_gate === 1'h1) c++;
    end
    chk("gate_off", 32'(e), 32'(c));
  endtask
  function automatic logic [7:0] cool();
    return 8'($urandom_range(255, 16));
  endfunction
  task automatic set_temp(input logic [7:0] hot);
    @(posedge aclk);
    on_die_temp_sensor <= {cool(), hot, cool(), cool()};
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'hEEF3B352));
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk("oe", 32'h0, 32'(package_hot_line_n_oe));
    rd(12'h000, {8'h00, CEIL, 16'h0000}, 32'h00FF_0000, 2'h0);
    wr(12'h000, 32'hFFFF_FFFF);
    rd(12'h000, {8'h00, CEIL, 16'h0000}, 32'h00FF_0000, 2'h0);
    rd(12'h020, 32'h0, 32'h0, 2'h2);
    wr(12'h004, 32'h0001_0000);
    set_temp(8'h00);
    wait_ratio(MIN_R);
    chk("oe", 32'h1, 32'(package_hot_line_n_oe));
    gate_cnt(48);
    rd(12'h00C, 32'h1, 32'h1, 2'h0);
    set_temp(cool());
    wait_ratio(MAX_R);
    chk("gate", 32'h0, 32'(core_clk_gate));
    wr(12'h004, 32'h0000_0005);
    set_temp(8'h03);
    wait_ratio(MIN_R);
    set_temp(cool());
    wait_ratio(MAX_R);
    wr(12'h004, 32'h0000_0302);
    set_temp(8'h00);
    wait_ratio(MIN_R);
    set_temp(cool());
    wait_ratio(MAX_R);
    wr(12'h004, 32'h0002_0000);
    hot_req <= 1'h1;
    wait_ratio(MIN_R);
    chk("irq", 32'h1, 32'(thermal_irq_req));
    gate_cnt(0);
    wr(12'h00C, 32'h0000_0002);
    chk("irq", 32'h0, 32'(thermal_irq_req));
    hot_req <= 1'h0;
    wait_ratio(MAX_R);
    summarize();
  end
endmodule
bind tthc_top tthc_properties #(.MIN_RATIO(MIN_RATIO), .GATE_CYC(GATE_CYC)) prop_u (.aclk,
  .aresetn, .package_hot_line_n_in, .package_hot_line_n_oe, .op_point, .exec_stall,
  .core_clk_gate, .s_axi_bvalid, .s_axi_bready);
